/* File: design/lsmc_pkg.sv */
// Package of the light sensor measure control register bank.
// Assumes a 32-bit APB slave where every register takes one aligned word.

package lsmc_pkg;

	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] IDX_MODDIS = 8'h40;
	localparam logic [7:0] IDX_ENABLE = 8'h80;
	localparam logic [7:0] IDX_MODE0 = 8'h81;
	localparam logic [7:0] IDX_MODE1 = 8'h82;
	localparam logic [7:0] IDX_EXTENT = 8'h30;
	localparam int ADDR_W = 12;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_MOD0_OFF = 0;
	localparam int BIT_MOD1_OFF = 1;
	localparam int BIT_PON = 0;
	localparam int BIT_AEN = 1;
	localparam int BIT_FLICKER_DETECT_ON = 6;
	localparam int BIT_HALT = 7;
	localparam int BIT_AGC2 = 6;
	localparam int BIT_ONESHOT = 5;
	localparam int BIT_LSTAT = 4;
	localparam int BIT_ENDTAG = 7;
	localparam int BIT_SUMW = 6;
	localparam int BIT_GAINW = 5;
	localparam int BIT_ENDLESS = 7;

	// ****************************************
	// Reset values and write masks
	// ****************************************
	localparam logic [7:0] RST_MODDIS = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_MODE0 = 8'h04;
	localparam logic [7:0] RST_MODE1 = 8'h0C;
	localparam logic [7:0] RST_EXTENT = 8'h00;
	localparam logic [7:0] MASK_MODDIS = 8'h03;
	localparam logic [7:0] MASK_ENABLE = 8'h43;
	localparam logic [3:0] AGC_STEP_RST = 4'h9;
	localparam logic [3:0] AGC_STEP_MAX = 4'hF;
	// Arbitrary marker value
	localparam logic [15:0] END_TAG_WORD = 16'hFFFF;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {KIND_LIGHT_STATUS, KIND_END_TAG, KIND_SUM, KIND_GAIN} lsmc_kind_t;

	typedef struct packed {
		lsmc_kind_t kind;
		logic [15:0] data;
	} lsmc_fifo_word_t;

	typedef struct packed {
		logic osc_run;
		logic mod0_run;
		logic mod1_run;
		logic flicker_run;
		logic light_run;
	} lsmc_ctrl_t;

endpackage

/* File: design/lsmc_ctrl_regs.sv */
// Measure control register bank with APB slave, run control, AGC step and FIFO metadata writer.
// Assumes measurement engine events arrive as one-cycle pulses synchronous to pclk.
//
// The APB slave port was decided locally.

// Contract
// - Bit 0 set keeps modulator 0 off
// - Bit 1 set keeps modulator 1 off
// - Flicker enable bit starts and stops flicker
// - Light enable bit starts and stops light measurement
// - Power bit runs oscillator, timers and modulators
// - Power off write clears both measurement enables
// - Halt mode clears enables after count, power stays
// - Default count halts after one measurement
// - Saturation with two-step mode drops gain two
// - One-shot sequencer cycle raises sleep after irq
// - Light status word goes into FIFO
// - Internal light result held 26 bits wide
// - Scale field picks scaled or unscaled data
// - End marker written after flicker measurement
// - Checksum written after flicker measurement
// - Gain written after flicker measurement
// - Top bit select picks reported light MSB
// - Endless repeat suppresses end markers
module lsmc_ctrl_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lsmc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic meas_iter_done,
	input wire logic agc_saturation,
	input wire logic agc_step_up,
	input wire logic seq_cycle_done,
	input wire logic flicker_meas_done,
	input wire logic [15:0] flicker_sum,
	input wire logic light_raw_valid,
	input wire logic [25:0] light_raw,
	output lsmc_pkg::lsmc_ctrl_t ctrl,
	output logic [3:0] agc_gain_step,
	output logic sleep_after_irq,
	output logic [15:0] light_data,
	output logic [7:0] light_status,
	output logic fifo_valid,
	output lsmc_pkg::lsmc_fifo_word_t fifo_word
);
	import lsmc_pkg::*;

	typedef enum {FS_IDLE, FS_TAG, FS_SUM, FS_GAIN} lsmc_fs_t;

	logic [7:0] moddis_reg;
	logic [7:0] enable_reg;
	logic [7:0] mode0_reg;
	logic [7:0] mode1_reg;
	logic [7:0] extent_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [8:0] dec;
	logic access;
	logic wr_en;
	logic wr_enable;
	logic [7:0] rd_mux;
	logic [7:0] enable_next;
	lsmc_ctrl_t ctrl_reg;
	logic [6:0] iter_cnt_reg;
	logic running;
	logic halt_fire;
	logic sleep_reg;
	logic [3:0] agc_step_reg;
	logic [31:0] result_reg;
	logic light_pipe_reg;
	logic [15:0] light_data_reg;
	logic [7:0] light_status_reg;
	logic [5:0] sh_unscaled;
	logic [5:0] sh_scaled;
	logic [15:0] unscaled;
	logic [15:0] scaled;
	logic use_scaled;
	logic pend_light_reg;
	logic pend_flick_reg;
	logic [15:0] sum_reg;
	logic tag_need;
	lsmc_fs_t fs_state;
	lsmc_fs_t fs_next;
	logic take_light;
	logic take_flick;
	logic word_valid_next;
	lsmc_fifo_word_t word_next;
	logic fifo_valid_reg;
	lsmc_fifo_word_t fifo_word_reg;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		logic hit;
		i = a[9:2];
		hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			(i == IDX_MODDIS || i == IDX_ENABLE || i == IDX_MODE0 || i == IDX_MODE1 || i == IDX_EXTENT);
		decode = {hit, i};
	endfunction

	// Shift of 32 or more yields zero, which is the wanted clamp
	function automatic logic [15:0] window16(input logic [31:0] v, input logic [5:0] sh);
		logic [31:0] t;
		t = v << sh;
		window16 = t[31:16];
	endfunction

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****************************************
	// APB slave
	// ****************************************
	// One wait state so read data comes from a flop
	assign dec = decode(paddr);
	assign access = psel & penable & pready_reg;
	assign wr_en = access & pwrite & dec[8];
	assign wr_enable = wr_en && (dec[7:0] == IDX_ENABLE);

	always_comb begin
		case (dec[7:0])
			IDX_MODDIS: rd_mux = moddis_reg;
			IDX_ENABLE: rd_mux = enable_reg;
			IDX_MODE0: rd_mux = mode0_reg;
			IDX_MODE1: rd_mux = mode1_reg;
			IDX_EXTENT: rd_mux = extent_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= psel & penable & ~pready_reg;
			pslverr_reg <= psel & penable & ~pready_reg & ~dec[8];
			if (psel & penable & ~pready_reg & ~pwrite) begin
				// Refused accesses read zero even when the index alone would hit
				prdata_reg <= dec[8] ? {24'h00_0000, rd_mux} : 32'h0000_0000;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	chk_reserved_zero: assert property (pready_reg |-> prdata_reg[31:8] == 24'h00_0000 &&
		moddis_reg[7:2] == 6'h00 && enable_reg[7] == 1'b0 && enable_reg[5:2] == 4'h0)
		else $error("reserved bits not zero");

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			moddis_reg <= RST_MODDIS;
			mode0_reg <= RST_MODE0;
			mode1_reg <= RST_MODE1;
			extent_reg <= RST_EXTENT;
		end else if (wr_en) begin
			case (dec[7:0])
				IDX_MODDIS: moddis_reg <= pwdata[7:0] & MASK_MODDIS;
				IDX_MODE0: mode0_reg <= pwdata[7:0];
				IDX_MODE1: mode1_reg <= pwdata[7:0];
				IDX_EXTENT: extent_reg <= pwdata[7:0];
				default: moddis_reg <= moddis_reg;
			endcase
		end
	end

	// ****************************************
	// Enable register and run control
	// ****************************************
	always_comb begin
		enable_next = pwdata[7:0] & MASK_ENABLE;
		if (!enable_next[BIT_PON]) begin
			enable_next = 8'h00;
		end
	end

	assign running = enable_reg[BIT_PON] & (enable_reg[BIT_FLICKER_DETECT_ON] | enable_reg[BIT_AEN]);
	// Limit counts extra iterations, so zero means a single one
	assign halt_fire = mode0_reg[BIT_HALT] & meas_iter_done & running &
		(iter_cnt_reg == extent_reg[6:0]);

	// Software write wins over a halt in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= RST_ENABLE;
		end else if (wr_enable) begin
			enable_reg <= enable_next;
		end else if (halt_fire) begin
			enable_reg[BIT_FLICKER_DETECT_ON] <= 1'b0;
			enable_reg[BIT_AEN] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iter_cnt_reg <= 7'h00;
		end else if (wr_enable || halt_fire) begin
			iter_cnt_reg <= 7'h00;
		end else if (meas_iter_done && running) begin
			iter_cnt_reg <= 7'(iter_cnt_reg + 7'h01);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= '0;
		end else begin
			ctrl_reg.osc_run <= enable_reg[BIT_PON];
			ctrl_reg.mod0_run <= enable_reg[BIT_PON] & ~moddis_reg[BIT_MOD0_OFF];
			ctrl_reg.mod1_run <= enable_reg[BIT_PON] & ~moddis_reg[BIT_MOD1_OFF];
			ctrl_reg.flicker_run <= enable_reg[BIT_PON] & enable_reg[BIT_FLICKER_DETECT_ON];
			ctrl_reg.light_run <= enable_reg[BIT_PON] & enable_reg[BIT_AEN];
		end
	end

	assign ctrl = ctrl_reg;

	chk_mod0_gate: assert property (moddis_reg[BIT_MOD0_OFF] |=> !ctrl_reg.mod0_run)
		else $error("modulator 0 runs while disabled");
	chk_mod1_gate: assert property (enable_reg[BIT_PON] && !moddis_reg[BIT_MOD1_OFF] &&
		moddis_reg[BIT_MOD0_OFF] |=> ctrl_reg.mod1_run && !ctrl_reg.mod0_run)
		else $error("modulator 1 not independent of modulator 0");
	chk_osc_follow: assert property (wr_enable && pwdata[BIT_PON] |=> ##1 ctrl_reg.osc_run)
		else $error("oscillator not started by power bit");
	chk_fd_write: assert property (wr_enable && pwdata[BIT_PON] && pwdata[BIT_FLICKER_DETECT_ON]
		|=> enable_reg[BIT_FLICKER_DETECT_ON] ##1 ctrl_reg.flicker_run)
		else $error("flicker enable write lost");
	chk_al_write: assert property (wr_enable && pwdata[BIT_PON] && !pwdata[BIT_AEN] |=> !enable_reg[BIT_AEN])
		else $error("light enable not cleared by write");
	chk_pon_clear: assert property (wr_enable && !pwdata[BIT_PON]
		|=> enable_reg == 8'h00 ##1 !ctrl_reg.flicker_run && !ctrl_reg.light_run)
		else $error("power off did not clear enables");
	chk_halt_stop: assert property (halt_fire && !wr_enable
		|=> !enable_reg[BIT_FLICKER_DETECT_ON] && !enable_reg[BIT_AEN] && enable_reg[BIT_PON])
		else $error("halt did not stop measurement");
	chk_halt_single: assert property (mode0_reg[BIT_HALT] && extent_reg[6:0] == 7'h00 &&
		iter_cnt_reg == 7'h00 && meas_iter_done && running && !wr_enable |=> !running)
		else $error("default count did not stop after one");

	// ****************************************
	// Sequencer single shot
	// ****************************************
	// Set wins over the clear by an enable write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_reg <= 1'b0;
		end else if (seq_cycle_done && mode0_reg[BIT_ONESHOT] && enable_reg[BIT_PON]) begin
			sleep_reg <= 1'b1;
		end else if (wr_enable) begin
			sleep_reg <= 1'b0;
		end
	end

	assign sleep_after_irq = sleep_reg;

	chk_one_shot: assert property (seq_cycle_done && mode0_reg[BIT_ONESHOT] && enable_reg[BIT_PON]
		|=> sleep_reg)
		else $error("single shot did not raise sleep");

	// ****************************************
	// Automatic gain step
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			agc_step_reg <= AGC_STEP_RST;
		end else if (agc_saturation && agc_step_reg != 4'h0) begin
			if (mode0_reg[BIT_AGC2] && agc_step_reg > 4'h1) begin
				agc_step_reg <= 4'(agc_step_reg - 4'h2);
			end else begin
				agc_step_reg <= 4'(agc_step_reg - 4'h1);
			end
		end else if (agc_step_up && agc_step_reg != AGC_STEP_MAX) begin
			agc_step_reg <= 4'(agc_step_reg + 4'h1);
		end
	end

	assign agc_gain_step = agc_step_reg;

	chk_agc_double: assert property (agc_saturation && mode0_reg[BIT_AGC2] && agc_step_reg > 4'h1
		|=> agc_step_reg == 4'($past(agc_step_reg) - 4'h2))
		else $error("two-step gain drop wrong");

	// ****************************************
	// Light result scaling
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= 32'h0000_0000;
			light_pipe_reg <= 1'b0;
		end else begin
			light_pipe_reg <= light_raw_valid;
			if (light_raw_valid) begin
				result_reg <= {6'h00, light_raw};
			end
		end
	end

	// Window top sits at the selected bit; scaling moves it down by the scale count
	assign sh_unscaled = 6'(6'd31 - {1'b0, mode1_reg[4:0]});
	assign sh_scaled = 6'(sh_unscaled + {2'h0, mode0_reg[3:0]});
	assign unscaled = window16(result_reg, sh_unscaled);
	assign scaled = window16(result_reg, sh_scaled);
	assign use_scaled = (unscaled & ~(16'hFFFF >> mode0_reg[3:0])) == 16'h0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			light_data_reg <= 16'h0000;
			light_status_reg <= 8'h00;
		end else if (light_pipe_reg) begin
			light_data_reg <= use_scaled ? scaled : unscaled;
			light_status_reg <= {3'h0, use_scaled, mode0_reg[3:0]};
		end
	end

	assign light_data = light_data_reg;
	assign light_status = light_status_reg;

	chk_result_width: assert property (result_reg[31:26] == 6'h00)
		else $error("light result wider than 26 bits");
	chk_scale_pick: assert property (light_pipe_reg && use_scaled |=> light_data_reg == $past(scaled))
		else $error("scaled value not reported");

	// ****************************************
	// FIFO metadata writer
	// ****************************************
	// Endless repeat never gets an end marker
	assign tag_need = mode1_reg[BIT_ENDTAG] & ~extent_reg[BIT_ENDLESS];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_light_reg <= 1'b0;
			pend_flick_reg <= 1'b0;
			sum_reg <= 16'h0000;
		end else begin
			if (light_pipe_reg && mode0_reg[BIT_LSTAT]) begin
				pend_light_reg <= 1'b1;
			end else if (take_light) begin
				pend_light_reg <= 1'b0;
			end
			if (flicker_meas_done && (tag_need || mode1_reg[BIT_SUMW] || mode1_reg[BIT_GAINW])) begin
				pend_flick_reg <= 1'b1;
				sum_reg <= flicker_sum;
			end else if (take_flick) begin
				pend_flick_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		fs_next = fs_state;
		take_light = 1'b0;
		take_flick = 1'b0;
		word_valid_next = 1'b0;
		word_next = '0;
		case (fs_state)
			FS_IDLE: begin
				if (pend_light_reg) begin
					take_light = 1'b1;
					word_valid_next = 1'b1;
					word_next.kind = KIND_LIGHT_STATUS;
					word_next.data = {8'h00, light_status_reg};
				end else if (pend_flick_reg) begin
					take_flick = 1'b1;
					fs_next = tag_need ? FS_TAG : mode1_reg[BIT_SUMW] ? FS_SUM :
						mode1_reg[BIT_GAINW] ? FS_GAIN : FS_IDLE;
				end
			end
			FS_TAG: begin
				word_valid_next = 1'b1;
				word_next.kind = KIND_END_TAG;
				word_next.data = END_TAG_WORD;
				fs_next = mode1_reg[BIT_SUMW] ? FS_SUM : mode1_reg[BIT_GAINW] ? FS_GAIN : FS_IDLE;
			end
			FS_SUM: begin
				word_valid_next = 1'b1;
				word_next.kind = KIND_SUM;
				word_next.data = sum_reg;
				fs_next = mode1_reg[BIT_GAINW] ? FS_GAIN : FS_IDLE;
			end
			FS_GAIN: begin
				word_valid_next = 1'b1;
				word_next.kind = KIND_GAIN;
				word_next.data = {12'h000, agc_step_reg};
				fs_next = FS_IDLE;
			end
			default: fs_next = FS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_state <= FS_IDLE;
			fifo_valid_reg <= 1'b0;
			fifo_word_reg <= '0;
		end else begin
			fs_state <= fs_next;
			fifo_valid_reg <= word_valid_next;
			fifo_word_reg <= word_next;
		end
	end

	assign fifo_valid = fifo_valid_reg;
	assign fifo_word = fifo_word_reg;

	sequence s_tag_out;
		fifo_valid_reg && fifo_word_reg.kind == KIND_END_TAG;
	endsequence
	sequence s_sum_out;
		fifo_valid_reg && fifo_word_reg.kind == KIND_SUM && fifo_word_reg.data == sum_reg;
	endsequence
	sequence s_gain_out;
		fifo_valid_reg && fifo_word_reg.kind == KIND_GAIN;
	endsequence

	chk_flick_order: assert property (take_flick && tag_need &&
		mode1_reg[BIT_SUMW] && mode1_reg[BIT_GAINW] |=> ##1 s_tag_out ##1 s_sum_out ##1 s_gain_out)
		else $error("flicker metadata order wrong");
	chk_gain_only: assert property (take_flick && !tag_need &&
		!mode1_reg[BIT_SUMW] && mode1_reg[BIT_GAINW] |=> ##1 s_gain_out)
		else $error("gain word missing");
	chk_endless_tag: assert property (extent_reg[BIT_ENDLESS] && fs_state == FS_IDLE
		|=> ##1 !(fifo_valid_reg && fifo_word_reg.kind == KIND_END_TAG))
		else $error("end marker in endless mode");
	chk_light_status: assert property (fs_state == FS_IDLE && pend_light_reg
		|=> fifo_valid_reg && fifo_word_reg.kind == KIND_LIGHT_STATUS)
		else $error("light status word missing");

endmodule

/* File: verif/light_sensor_measure_control_test.sv */
// Self-checking bench for the measure control register bank.
// Assumes lsmc_pkg is compiled first; the bench drives every port itself.
module light_sensor_measure_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import lsmc_pkg::*;

	// ****************************************
	// Signals and instance
	// ****************************************
	localparam logic [11:0] A_MODDIS = {2'b00, IDX_MODDIS, 2'b00};
	localparam logic [11:0] A_ENABLE = {2'b00, IDX_ENABLE, 2'b00};
	localparam logic [11:0] A_MODE0 = {2'b00, IDX_MODE0, 2'b00};
	localparam logic [11:0] A_MODE1 = {2'b00, IDX_MODE1, 2'b00};
	localparam logic [11:0] A_EXTENT = {2'b00, IDX_EXTENT, 2'b00};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] ev;
	logic [15:0] flicker_sum, light_data, exp_data;
	logic [25:0] light_raw;
	lsmc_ctrl_t ctrl;
	logic [3:0] agc_gain_step;
	logic sleep_after_irq, fifo_valid, used;
	logic [7:0] light_status;
	lsmc_fifo_word_t fifo_word;
	lsmc_fifo_word_t seen_q[$];
	int fail_count, check_count, cycle_count;
	logic [25:0] lr [4] = '{26'h000_0ABC, 26'h01F_FFFF, 26'h001_2345, 26'h200_0000};
	int lt [4] = '{12, 20, 20, 25};
	int ls [4] = '{4, 0, 4, 4};

	lsmc_ctrl_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas_iter_done(ev[0]), .agc_saturation(ev[1]), .agc_step_up(ev[2]), .seq_cycle_done(ev[3]),
		.flicker_meas_done(ev[4]), .flicker_sum(flicker_sum), .light_raw_valid(ev[5]), .light_raw(light_raw),
		.ctrl(ctrl), .agc_gain_step(agc_gain_step), .sleep_after_irq(sleep_after_irq),
		.light_data(light_data), .light_status(light_status), .fifo_valid(fifo_valid), .fifo_word(fifo_word));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (fifo_valid === 1'b1) begin
			seen_q.push_back(fifo_word);
		end
	end

	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge pclk) begin
		cycle_count++;
		if (cycle_count == 5000) begin
			fail_count++;
			stop_test();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Request held until pready is seen high; data and error taken at that edge
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
	endtask

	task automatic rd_check(input string what, input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, addr, 32'h0000_0000);
		check(what, exp, rd);
		check({what, " error"}, {31'b0, exp_err}, {31'b0, er});
	endtask

	task automatic pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev[i] <= 1'b0;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic flicker_run();
		seen_q.delete();
		pulse(4);
		settle(8);
	endtask

	// Reported window of 16 bits whose top sits at bit top; zeros below bit 0
	function automatic logic [15:0] window(input logic [25:0] raw, input int top);
		logic [47:0] w;
		w = {6'b0, raw, 16'b0};
		return w[top+16 -: 16];
	endfunction

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		ev = '0;
		flicker_sum = 16'h0000;
		light_raw = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("ctrl", 32'h0, {27'b0, ctrl});
		check("gain step", 32'h9, {28'b0, agc_gain_step});
		rd_check("moddis", A_MODDIS, 32'h00, 1'b0);
		rd_check("enable", A_ENABLE, 32'h00, 1'b0);
		rd_check("mode0", A_MODE0, 32'h04, 1'b0);
		rd_check("mode1", A_MODE1, 32'h0C, 1'b0);
		wr(A_MODDIS, 32'hFFFF_FFFF);
		rd_check("moddis", A_MODDIS, 32'h03, 1'b0);
		wr(A_ENABLE, 32'hFFFF_FFFF);
		rd_check("enable", A_ENABLE, 32'h43, 1'b0);
		check("ctrl", 32'h13, {27'b0, ctrl});
		wr(A_MODDIS, 32'h01);
		settle(2);
		check("ctrl", 32'h17, {27'b0, ctrl});
		wr(A_MODDIS, 32'h02);
		settle(2);
		check("ctrl", 32'h1B, {27'b0, ctrl});
		wr(A_MODDIS, 32'h00);
		wr(A_ENABLE, 32'h41);
		settle(2);
		check("ctrl", 32'h1E, {27'b0, ctrl});
		wr(A_ENABLE, 32'h03);
		settle(2);
		check("ctrl", 32'h1D, {27'b0, ctrl});
		wr(A_ENABLE, 32'h42);
		rd_check("enable", A_ENABLE, 32'h00, 1'b0);
		check("ctrl", 32'h00, {27'b0, ctrl});
		rd_check("unmapped", 12'h300, 32'h00, 1'b1);
		rd_check("unaligned", 12'h205, 32'h00, 1'b1);
		wr(12'h300, 32'h55);
		check("write error", 32'h1, {31'b0, er});

		// ****************************************
		// Halt after count, default and extended
		// ****************************************
		wr(A_MODE0, 32'h84);
		wr(A_ENABLE, 32'h43);
		pulse(0);
		settle(3);
		rd_check("enable", A_ENABLE, 32'h01, 1'b0);
		check("ctrl", 32'h1C, {27'b0, ctrl});
		wr(A_EXTENT, 32'h01);
		wr(A_ENABLE, 32'h43);
		pulse(0);
		settle(3);
		rd_check("enable", A_ENABLE, 32'h43, 1'b0);
		pulse(0);
		settle(3);
		rd_check("enable", A_ENABLE, 32'h01, 1'b0);
		wr(A_EXTENT, 32'h00);
		wr(A_MODE0, 32'h04);
		wr(A_ENABLE, 32'h43);
		pulse(0);
		settle(3);
		rd_check("enable", A_ENABLE, 32'h43, 1'b0);

		// ****************************************
		// Gain control and single shot
		// ****************************************
		wr(A_MODE0, 32'h44);
		pulse(1);
		settle(2);
		check("gain step", 32'h7, {28'b0, agc_gain_step});
		wr(A_MODE0, 32'h04);
		pulse(1);
		settle(2);
		check("gain step", 32'h6, {28'b0, agc_gain_step});
		pulse(2);
		settle(2);
		check("gain step", 32'h7, {28'b0, agc_gain_step});
		pulse(3);
		settle(2);
		check("sleep", 32'h0, {31'b0, sleep_after_irq});
		wr(A_MODE0, 32'h24);
		pulse(3);
		settle(2);
		check("sleep", 32'h1, {31'b0, sleep_after_irq});
		wr(A_ENABLE, 32'h01);
		settle(2);
		check("sleep", 32'h0, {31'b0, sleep_after_irq});

		// ****************************************
		// Metadata written into the sample queue
		// ****************************************
		wr(A_MODE0, 32'h04);
		wr(A_MODE1, 32'hEC);
		flicker_sum <= 16'h1234;
		flicker_run();
		check("fifo count", 32'd3, 32'(seen_q.size()));
		check("fifo tag", {14'b0, KIND_END_TAG, END_TAG_WORD}, {14'b0, seen_q[0]});
		check("fifo sum", {14'b0, KIND_SUM, 16'h1234}, {14'b0, seen_q[1]});
		check("fifo gain", {14'b0, KIND_GAIN, 16'h0007}, {14'b0, seen_q[2]});
		wr(A_EXTENT, 32'h80);
		flicker_run();
		check("fifo count", 32'd2, 32'(seen_q.size()));
		check("fifo sum", {14'b0, KIND_SUM, 16'h1234}, {14'b0, seen_q[0]});
		wr(A_EXTENT, 32'h00);
		wr(A_MODE1, 32'h2C);
		flicker_run();
		check("fifo count", 32'd1, 32'(seen_q.size()));
		check("fifo gain", {14'b0, KIND_GAIN, 16'h0007}, {14'b0, seen_q[0]});
		wr(A_MODE1, 32'h0C);
		flicker_run();
		check("fifo count", 32'd0, 32'(seen_q.size()));
		wr(A_MODE0, 32'h14);
		seen_q.delete();
		pulse(5);
		settle(6);
		check("fifo count", 32'd1, 32'(seen_q.size()));
		check("fifo kind", {30'b0, KIND_LIGHT_STATUS}, {30'b0, seen_q[0].kind});

		// ****************************************
		// Light value window and scaling
		// ****************************************
		for (int k = 0; k < 4; k++) begin
			wr(A_MODE0, 32'(ls[k]));
			wr(A_MODE1, 32'(lt[k]));
			light_raw <= lr[k];
			pulse(5);
			settle(4);
			exp_data = window(lr[k], lt[k]);
			used = (ls[k] == 0) || ((exp_data >> (16 - ls[k])) == 16'h0000);
			if (used) begin
				exp_data = window(lr[k], lt[k] - ls[k]);
			end
			check("light data", {16'b0, exp_data}, {16'b0, light_data});
			check("light status", {27'b0, used, 4'(ls[k])}, {24'b0, light_status});
		end
		stop_test();
	end
endmodule
